// *** eeprom_host_pkg.sv ***
// Constants and types shared by the parallel EEPROM page-write host.
// Assumes a 50 MHz system clock; all timing counts derive from it.
package eeprom_host_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_BITS = 5;
  localparam int PAGE_BYTES = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 20;

  // ==========================================================
  // Timing in own units and derived cycle counts
  localparam int CLK_MHZ = 50;
  localparam int STROBE_NS = 200;
  localparam int SETUP_NS = 100;
  localparam int HOLD_NS = 150;
  localparam int BYTE_LOAD_INTERVAL_US = 30;
  localparam int PAGE_LOAD_TIMEOUT_US = 100;
  localparam int PROGRAM_CYCLE_TIME_MS = 10;
  localparam int READ_ACCESS_NS = 250;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + 2;
  localparam int LOAD_GAP_CYC = BYTE_LOAD_INTERVAL_US * CLK_MHZ;
  localparam int CLOSE_CYC = PAGE_LOAD_TIMEOUT_US * CLK_MHZ;
  localparam int PROG_CYC = PROGRAM_CYCLE_TIME_MS * 1000 * CLK_MHZ;

  // ==========================================================
  // Host sequencer states
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_SETUP = 8'h02,
    ST_STRB  = 8'h04,
    ST_HOLD  = 8'h08,
    ST_GAP   = 8'h10,
    ST_CLOSE = 8'h20,
    ST_POLL  = 8'h40,
    ST_WAIT  = 8'h80
  } host_state_type;
endpackage : eeprom_host_pkg

// *** byte_stream_if.sv ***
// Valid/ready carrier for address/data words inside the host.
// Assumes one clock domain; the producer owns valid and payload.
interface byte_stream_if #(parameter int WIDTH = 21);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] payload;
  modport source (output valid, output payload, input ready);
  modport sink   (input valid, input payload, output ready);
endinterface : byte_stream_if

// *** stream_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
module stream_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  byte_stream_if.sink   in_s,
  byte_stream_if.source out_s
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // ==========================================================
  // Pointer and fill next values
  always_comb
  begin
    push = in_s.valid && in_s.ready;
    pop  = out_s.valid && out_s.ready;
    wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage array
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_s.payload;
  end

  assign in_s.ready    = (cnt_q != (PW+1)'(DEPTH)); // Full stalls producer
  assign out_s.valid   = (cnt_q != '0);
  assign out_s.payload = mem[rd_q];
endmodule : stream_fifo

// *** eeprom_page_host.sv ***
// Host controller driving a parallel EEPROM page write over its pins.
// Assumes the EEPROM pins are external; inputs from pins are synchronised.
module eeprom_page_host
  import eeprom_host_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  input  wire logic                                  host_stable,
  input  wire logic                                  use_polling,
  input  wire logic                                  wr_valid,
  input  wire logic [eeprom_host_pkg::ADDR_W-1:0]    wr_addr,
  input  wire logic [eeprom_host_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                                  wr_last,
  output logic                                       wr_ready,
  output logic                                       busy,
  output logic                                       page_done,
  output logic [eeprom_host_pkg::ADDR_W-1:0]         address_lines,
  output logic [eeprom_host_pkg::DATA_W-1:0]         data_out,
  output logic                                       data_oe_n,
  input  wire logic [eeprom_host_pkg::DATA_W-1:0]    data_in,
  input  wire logic                                  rdy_busy_in,
  output logic                                       chip_sel_n,
  output logic                                       out_en_n,
  output logic                                       wr_strobe_n
);
  import eeprom_host_pkg::*;

  // Buffered word: page-end marker, address, data
  localparam int PW = ADDR_W + DATA_W + 1;
  // Last chain start keeps the next strobe fall inside the load interval
  localparam int CHAIN_CYC = LOAD_GAP_CYC - SETUP_CYC - HOLD_CYC - 3;

  byte_stream_if #(.WIDTH(PW)) in_if ();
  byte_stream_if #(.WIDTH(PW)) out_if ();

  host_state_type          st_q, st_d;
  logic [CNT_W-1:0]        cnt_q, cnt_d;
  logic [23:0]             prog_q, prog_d;
  logic [5:0]              nbytes_q, nbytes_d;
  logic [ADDR_W-1:0]       addr_q, addr_d;
  logic [DATA_W-1:0]       dout_q, dout_d;
  logic                    last_bit_q, last_bit_d;
  logic                    oe_q, oe_d, cs_q, cs_d, we_q, we_d, doe_q, doe_d;
  logic                    done_q, done_d, last_q, last_d;
  logic [DATA_W-1:0]       din_s1, din_s2;
  logic                    rb_s1, rb_s2, stable_s1, stable_s2;
  logic                    same_page;

  // ==========================================================
  // Input word buffer
  assign in_if.valid   = wr_valid;
  assign in_if.payload = {wr_last, wr_addr, wr_data}; // Marker travels with its byte
  assign wr_ready      = in_if.ready;

  stream_fifo #(.WIDTH(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .in_s    (in_if.sink),
    .out_s   (out_if.source)
  );

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk)
  begin
    din_s1    <= data_in;
    din_s2    <= din_s1;
    rb_s1     <= rdy_busy_in;
    rb_s2     <= rb_s1;
    stable_s1 <= host_stable;
    stable_s2 <= stable_s1;
  end

  assign same_page = (out_if.payload[PW-2:DATA_W+PAGE_BITS]
                      == addr_q[ADDR_W-1:PAGE_BITS]);

  // ==========================================================
  // Sequencer next state
  always_comb
  begin
    st_d       = st_q;
    cnt_d      = cnt_q + 1'b1;
    prog_d     = prog_q;
    nbytes_d   = nbytes_q;
    addr_d     = addr_q;
    dout_d     = dout_q;
    last_bit_d = last_bit_q;
    cs_d       = 1'b1;
    oe_d       = 1'b1;
    we_d       = 1'b1;
    doe_d      = 1'b1;
    done_d     = 1'b0;
    last_d     = last_q;
    out_if.ready = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        cnt_d = '0;
        if (stable_s2 && out_if.valid)
        begin
          out_if.ready = 1'b1;
          addr_d   = out_if.payload[PW-2:DATA_W];
          dout_d   = out_if.payload[DATA_W-1:0];
          last_d   = out_if.payload[PW-1];
          nbytes_d = 6'h01;
          st_d     = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        cs_d  = 1'b0;
        doe_d = 1'b0;
        if (cnt_q >= CNT_W'(SETUP_CYC))
        begin
          we_d  = 1'b0;
          cnt_d = '0;
          st_d  = ST_STRB;
        end
      end
      ST_STRB:
      begin
        cs_d  = 1'b0;
        doe_d = 1'b0;
        we_d  = 1'b0;
        if (cnt_q >= CNT_W'(STROBE_CYC))
        begin
          we_d       = 1'b1;
          last_bit_d = dout_q[DATA_W-1];
          cnt_d      = '0;
          st_d       = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        cs_d  = 1'b0;
        doe_d = 1'b0;
        if (cnt_q >= CNT_W'(HOLD_CYC))
        begin
          cnt_d = '0;
          st_d  = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // Chain bytes while within the load interval; wait on an empty buffer
        if (!last_q && out_if.valid && same_page && nbytes_q < 6'(PAGE_BYTES)
            && cnt_q < CNT_W'(CHAIN_CYC))
        begin
          out_if.ready = 1'b1;
          addr_d   = out_if.payload[PW-2:DATA_W];
          dout_d   = out_if.payload[DATA_W-1:0];
          last_d   = out_if.payload[PW-1];
          nbytes_d = nbytes_q + 1'b1;
          cnt_d    = '0;
          st_d     = ST_SETUP;
        end
        else if (last_q || (out_if.valid && !same_page) || nbytes_q >= 6'(PAGE_BYTES)
                 || cnt_q >= CNT_W'(CHAIN_CYC))
        begin
          cnt_d = '0;
          st_d  = ST_CLOSE;
        end
      end
      ST_CLOSE:
      begin
        // Let the device close the page on its own
        if (cnt_q >= CNT_W'(CLOSE_CYC))
        begin
          cnt_d  = '0;
          prog_d = '0;
          st_d   = use_polling ? ST_POLL : ST_WAIT;
        end
      end
      ST_POLL:
      begin
        cs_d   = 1'b0;
        oe_d   = 1'b0;
        prog_d = prog_q + 1'b1;
        if (cnt_q >= CNT_W'(READ_CYC))
        begin
          cnt_d = '0;
          if (din_s2[DATA_W-1] == last_bit_q && rb_s2)
          begin
            done_d = 1'b1;
            cs_d   = 1'b1; // Release the read as busy drops
            oe_d   = 1'b1;
            st_d   = ST_IDLE;
          end
          else if (prog_q >= 24'(PROG_CYC))
            st_d = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        prog_d = prog_q + 1'b1;
        if (prog_q >= 24'(PROG_CYC))
        begin
          done_d = 1'b1;
          st_d   = ST_IDLE;
        end
      end
      default:
        st_d = ST_IDLE;
    endcase
    if (cnt_q == {CNT_W{1'b1}})
      cnt_d = cnt_q;
  end

  // Sequencer registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q       <= ST_IDLE;
      cnt_q      <= '0;
      prog_q     <= '0;
      nbytes_q   <= '0;
      addr_q     <= '0;
      dout_q     <= '0;
      last_bit_q <= 1'b0;
      cs_q       <= 1'b1;
      oe_q       <= 1'b1;
      we_q       <= 1'b1;
      doe_q      <= 1'b1;
      done_q     <= 1'b0;
      last_q     <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      prog_q     <= prog_d;
      nbytes_q   <= nbytes_d;
      addr_q     <= addr_d;
      dout_q     <= dout_d;
      last_bit_q <= last_bit_d;
      cs_q       <= cs_d;
      oe_q       <= oe_d;
      we_q       <= we_d;
      doe_q      <= doe_d;
      done_q     <= done_d;
      last_q     <= last_d;
    end
  end

  // Busy flag, registered from state
  logic busy_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      busy_q <= 1'b0;
    else
      busy_q <= (st_d != ST_IDLE);
  end

  // ==========================================================
  // Outputs other than wr_ready, all from flip-flops
  assign address_lines = addr_q;
  assign data_out      = dout_q;
  assign data_oe_n     = doe_q;
  assign chip_sel_n    = cs_q;
  assign out_en_n      = oe_q;
  assign wr_strobe_n   = we_q;
  assign page_done     = done_q;
  assign busy          = busy_q;
endmodule : eeprom_page_host

// *** eeprom_host_props.sv ***
// Checker for the EEPROM host pin sequencing.
// Assumes only the top-level ports; bound after the module.
module eeprom_host_props
  import eeprom_host_pkg::*;
(
  input wire logic                               clk,
  input wire logic                               sys_rst,
  input wire logic                               chip_sel_n,
  input wire logic                               out_en_n,
  input wire logic                               wr_strobe_n,
  input wire logic                               data_oe_n,
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] address_lines,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] data_out,
  input wire logic                               busy,
  input wire logic                               page_done
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_gate;
    !wr_strobe_n |-> !chip_sel_n && out_en_n && !data_oe_n;
  endproperty
  property p_width;
    $fell(wr_strobe_n) |-> (!wr_strobe_n)[*8];
  endproperty
  property p_gap;
    $rose(wr_strobe_n) |-> wr_strobe_n[*8];
  endproperty
  property p_stable;
    !wr_strobe_n && !$fell(wr_strobe_n) |-> $stable(data_out) && $stable(address_lines);
  endproperty
  property p_rise;
    $rose(wr_strobe_n) |-> !data_oe_n && !chip_sel_n && $stable(data_out);
  endproperty
  property p_read;
    !out_en_n |-> data_oe_n && wr_strobe_n && busy;
  endproperty
  property p_reset;
    $fell(sys_rst) |-> wr_strobe_n && chip_sel_n && data_oe_n && !busy;
  endproperty
  property p_done;
    page_done |-> $past(busy) ##1 !page_done;
  endproperty
  a_gate: assert property (p_gate) else $error("strobe outside write select");
  a_width: assert property (p_width) else $error("strobe pulse too short");
  a_gap: assert property (p_gap) else $error("strobe high time too short");
  a_stable: assert property (p_stable) else $error("bus moved in strobe");
  a_rise: assert property (p_rise) else $error("data lost at strobe rise");
  a_read: assert property (p_read) else $error("bad poll read cycle");
  a_reset: assert property (p_reset) else $error("no inhibit after reset");
  a_done: assert property (p_done) else $error("bad done pulse");
  c_write: cover property ($rose(wr_strobe_n));
  c_poll: cover property (!out_en_n);
  c_done: cover property (page_done);
endmodule : eeprom_host_props

bind eeprom_page_host eeprom_host_props i_props (.clk(clk), .sys_rst(sys_rst),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
  .data_oe_n(data_oe_n), .address_lines(address_lines), .data_out(data_out),
  .busy(busy), .page_done(page_done));

// *** eeprom_model.sv ***
// Behavioural page-write EEPROM at the far side of the host.
// Assumes the host clock only for long timers; ready/busy pulled up.
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter int CLOSE_T = CLOSE_CYC,
  parameter int PROG_T  = 3000
) (
  input  wire logic                               clk,
  input  wire logic                               chip_sel_n,
  input  wire logic                               out_en_n,
  input  wire logic                               wr_strobe_n,
  input  wire logic [eeprom_host_pkg::ADDR_W-1:0] address_lines,
  input  wire logic [eeprom_host_pkg::DATA_W-1:0] data_out,
  input  wire logic                               data_oe_n,
  output logic      [eeprom_host_pkg::DATA_W-1:0] data_in,
  output logic                                    rdy_busy_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Page latch and array
  logic [DATA_W-1:0]     mem [0:8191];
  logic [DATA_W-1:0]     page [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] loaded = '0;
  logic [ADDR_W-1:0]     adr;
  logic [ADDR_W-1:0]     upper;
  logic [DATA_W-1:0]     last = '0;
  logic [DATA_W-1:0]     flt = 8'h5a;
  logic                  open = 1'b0;
  logic                  prog = 1'b0;
  logic                  low_seen = 1'b0;
  int                    idle = 0;
  int                    pcnt = 0;
  int                    strobes = 0;
  realtime               t_fall = 0.0;
  // Address on falling strobe
  always @(negedge wr_strobe_n)
  begin
    if (!chip_sel_n && out_en_n && !prog)
    begin
      adr = address_lines;
      t_fall = $realtime;
    end
  end
  // Data on rising strobe, short pulses dropped
  always @(posedge wr_strobe_n)
  begin
    if (!chip_sel_n && out_en_n && !prog && $realtime - t_fall > 20.0)
    begin
      page[adr[PAGE_BITS-1:0]] = data_in;
      loaded[adr[PAGE_BITS-1:0]] = 1'b1;
      upper = adr;
      last = data_in;
      open = 1'b1;
      idle = 0;
      strobes++;
    end
  end
  // Page close, program timer, floating pattern
  always @(posedge clk)
  begin
    flt <= ~flt;
    if (open && (chip_sel_n || wr_strobe_n))
      idle++;
    else
      idle = 0;
    if (open && idle >= CLOSE_T)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
        if (loaded[i])
          mem[{upper[ADDR_W-1:PAGE_BITS], PAGE_BITS'(i)}] = page[i];
      loaded = '0;
      open = 1'b0;
      prog = 1'b1;
      pcnt = 0;
    end
    else if (prog)
    begin
      pcnt++;
      if (pcnt >= PROG_T)
        prog = 1'b0;
    end
    low_seen = low_seen | !rdy_busy_in;
  end
  // Open-drain busy and shared data lines
  assign rdy_busy_in = (open || prog) ? 1'b0 : 1'b1;
  assign data_in = !data_oe_n ? data_out
                 : (chip_sel_n || out_en_n || !wr_strobe_n) ? flt
                 : prog ? {~last[DATA_W-1], last[DATA_W-2:0] ^ 7'h55}
                 : mem[address_lines];
endmodule : eeprom_model

// *** tb_top.sv ***
// Self-checking bench for the EEPROM page-write host.
// Assumes the device model and the bound checker are compiled.
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_top
  import eeprom_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals and instances
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              host_stable = 1'b1;
  logic              use_polling = 1'b1;
  logic              wr_valid = 1'b0;
  logic              wr_last = 1'b0;
  logic [ADDR_W-1:0] wr_addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_ready, busy, page_done, data_oe_n, rdy_busy_in;
  logic              chip_sel_n, out_en_n, wr_strobe_n;
  logic [ADDR_W-1:0] address_lines;
  logic [DATA_W-1:0] data_out, data_in;
  logic              saw_full = 1'b0;
  int                err_total = 0;
  int                checks_done = 0;
  always #10 clk = ~clk;
  eeprom_page_host i_dut (.clk(clk), .sys_rst(sys_rst), .host_stable(host_stable),
    .use_polling(use_polling), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_last(wr_last), .wr_ready(wr_ready), .busy(busy), .page_done(page_done),
    .address_lines(address_lines), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in), .rdy_busy_in(rdy_busy_in), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n));
  eeprom_model i_model (.clk(clk), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .wr_strobe_n(wr_strobe_n), .address_lines(address_lines), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in), .rdy_busy_in(rdy_busy_in));
  // ==========================================================
  // Shared tasks
  task automatic summarize;
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic push(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic l);
    int n;
    @(negedge clk);
    wr_valid = 1'b1;
    wr_addr = a;
    wr_data = d;
    wr_last = l;
    for (n = 0; n < 400 && wr_ready !== 1'b1; n++)
    begin
      saw_full = 1'b1;
      @(negedge clk);
    end
    if (n == 400)
    begin
      err_total++;
      summarize();
    end
    @(negedge clk);
    wr_valid = 1'b0;
  endtask : push
  task automatic wait_done;
    int n;
    for (n = 0; n < 30000 && page_done !== 1'b1; n++)
      @(negedge clk);
    `CHK("page_done", 1'b1, page_done)
    if (n == 30000)
      summarize();
  endtask : wait_done
  task automatic run_page(input logic [ADDR_W-1:0] base, input int cnt);
    int s0;
    s0 = i_model.strobes;
    for (int i = 0; i < cnt; i++)
      push(ADDR_W'(base + i), DATA_W'(base + i * 41), i == cnt - 1);
    wait_done();
    `CHK("strobes", cnt, i_model.strobes - s0)
    for (int i = 0; i < cnt; i++)
      `CHK("mem", DATA_W'(base + i * 41), i_model.mem[ADDR_W'(base + i)])
  endtask : run_page
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    @(negedge clk);
    `CHK("inhibit", 5'h17, {wr_ready, busy, wr_strobe_n, chip_sel_n, data_oe_n})
  endtask : t_reset
  task automatic t_single;
    `CHK("rdy_idle", 1'b1, rdy_busy_in)
    run_page(13'h0a47, 1);
    `CHK("rdy_low", 1'b1, i_model.low_seen)
    `CHK("rdy_end", 1'b1, rdy_busy_in)
  endtask : t_single
  task automatic t_full;
    run_page(13'h01e0, 32);
    `CHK("refused", 1'b1, saw_full)
  endtask : t_full
  task automatic t_unstable;
    int s0;
    host_stable = 1'b0;
    s0 = i_model.strobes;
    push(13'h0c05, 8'h9c, 1'b1);
    repeat (300) @(negedge clk);
    `CHK("no_write", s0, i_model.strobes)
    host_stable = 1'b1;
    wait_done();
    `CHK("mem", 8'h9c, i_model.mem[13'h0c05])
  endtask : t_unstable
  // Fixed wait without polling, then a reset in mid-wait
  task automatic t_nopoll;
    logic seen;
    seen = 1'b0;
    use_polling = 1'b0;
    push(13'h0123, 8'h3c, 1'b1);
    repeat (10000)
    begin
      @(negedge clk);
      seen = seen | page_done;
    end
    `CHK("early_done", 1'b0, seen)
    `CHK("wait_busy", 1'b1, busy)
    `CHK("mem", 8'h3c, i_model.mem[13'h0123])
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    use_polling = 1'b1;
    t_reset();
  endtask : t_nopoll
  initial
  begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_single();
    t_full();
    t_nopoll();
    t_unstable();
    summarize();
  end
endmodule : tb_top
